// File: hdl/pwm_fos_regs.vh
// Constants for the PWM forced output stop block
`ifndef PWM_FOS_REGS_VH
`define PWM_FOS_REGS_VH
`define PWM_CNT_W 16
`define PWM_PERIOD_RST 16'hFFFF
`define PWM_DUTY_RST 16'h0000
`define PWM_INACTIVE_LVL 1'b1
`define FOS_ST_RUN 1'b0
`define FOS_ST_STOP 1'b1
`endif

// File: hdl/pwm_channel.v
// One PWM compare channel with forced stop gating
`include "pwm_fos_regs.vh"
`default_nettype none
module pwm_channel #(
    parameter W = 16
) (
    // Clock and reset
    input wire mclk_i,
    input wire resetn_i,
    // Counter and compare
    input wire [W-1:0] count_i,
    input wire [W-1:0] duty_i,
    // Stop control
    input wire stop_i,
    input wire hiz_mode_i,
    // Pin
    output reg pin_o,
    output reg pin_oe_o
);
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else if (stop_i) begin
            // Inactive level or released pin, no software involved
            pin_o <= `PWM_INACTIVE_LVL;
            pin_oe_o <= ~hiz_mode_i;
        end else begin
            pin_o <= (count_i < duty_i);
            pin_oe_o <= 1'b1;
        end
    end
endmodule // pwm_channel
`default_nettype wire

// File: hdl/pwm_forced_output_stop.v
// 16-bit PWM timer with over-current forced output stop
`include "pwm_fos_regs.vh"
`default_nettype none
module pwm_forced_output_stop #(
    parameter CNT_W = `PWM_CNT_W
) (
    // Clock and reset
    input wire mclk_i,
    input wire resetn_i,
    // Timer control
    input wire timer_enable_i,
    input wire [CNT_W-1:0] period_i,
    input wire [CNT_W-1:0] duty_ch0_i,
    input wire [CNT_W-1:0] duty_ch1_i,
    // Stop control
    input wire hiz_mode_i,
    input wire stop_cancel_trigger_i,
    // Over-current comparator result, sense above threshold_dac reference
    input wire overcurrent_comparator_i,
    // PWM pins
    output wire pwm_out_ch0_o,
    output wire pwm_out_ch0_oe_o,
    output wire pwm_out_ch1_o,
    output wire pwm_out_ch1_oe_o,
    // Status
    output reg overcurrent_flag_o,
    output reg forced_stop_o,
    output reg [CNT_W-1:0] count_o
);
    reg flag_prev;
    reg next_stop;
    reg [CNT_W-1:0] next_count;
    wire [1:0] stop_vec;
    wire [CNT_W-1:0] duty_vec [0:1];
    wire [1:0] pin_vec;
    wire [1:0] oe_vec;

    // Flag follows comparator; reference set by the DAC outside
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overcurrent_flag_o <= 1'b0;
            flag_prev <= 1'b0;
        end else begin
            overcurrent_flag_o <= overcurrent_comparator_i;
            flag_prev <= overcurrent_flag_o;
        end
    end

    // Edge sets, accepted cancel clears; set wins on a tie
    always @* begin
        next_stop = forced_stop_o;
        if (stop_cancel_trigger_i && !overcurrent_flag_o) begin
            next_stop = `FOS_ST_RUN;
        end
        if (overcurrent_flag_o && !flag_prev) begin
            next_stop = `FOS_ST_STOP;
        end
        // Cancel while flag high changes nothing
        if (overcurrent_flag_o && forced_stop_o) begin
            next_stop = `FOS_ST_STOP;
        end
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            forced_stop_o <= `FOS_ST_RUN;
        end else begin
            forced_stop_o <= next_stop;
        end
    end

    // Free-running up counter, wraps at period
    always @* begin
        next_count = count_o;
        if (timer_enable_i) begin
            if (count_o >= period_i) begin
                next_count = {CNT_W{1'b0}};
            end else begin
                next_count = count_o + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= {CNT_W{1'b0}};
        end else begin
            count_o <= next_count;
        end
    end

    // Only channel 0 is guarded; channel 1 keeps running
    assign stop_vec = {1'b0, next_stop};
    assign duty_vec[0] = duty_ch0_i;
    assign duty_vec[1] = duty_ch1_i;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            pwm_channel #(
                .W(CNT_W)
            ) u_ch (
                .mclk_i(mclk_i),
                .resetn_i(resetn_i),
                .count_i(next_count),
                .duty_i(duty_vec[g]),
                .stop_i(stop_vec[g]),
                .hiz_mode_i(hiz_mode_i),
                .pin_o(pin_vec[g]),
                .pin_oe_o(oe_vec[g])
            );
        end
    endgenerate

    assign pwm_out_ch0_o = pin_vec[0];
    assign pwm_out_ch0_oe_o = oe_vec[0];
    assign pwm_out_ch1_o = pin_vec[1];
    assign pwm_out_ch1_oe_o = oe_vec[1];
endmodule // pwm_forced_output_stop
`default_nettype wire

// File: testbench/pwm_fos_assertions.sv
// Port assertions for the forced output stop block
`default_nettype none
module pwm_fos_assertions (
    input wire logic mclk_i, resetn_i, hiz_mode_i, stop_cancel_trigger_i,
    input wire logic overcurrent_comparator_i, overcurrent_flag_o, forced_stop_o,
    input wire logic pwm_out_ch0_o, pwm_out_ch0_oe_o, pwm_out_ch1_oe_o
);
    timeunit 1ns/1ps;
    wire c = overcurrent_comparator_i, f = overcurrent_flag_o;
    wire s = forced_stop_o, k = stop_cancel_trigger_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence trip_s; $rose(f); endsequence
    sequence ok_s; k && !f; endsequence
    flag_rise_a: assert property ($rose(c) |=> f) else $error("rise");
    flag_fall_a: assert property ($fell(c) |=> !f) else $error("fall");
    stop_trip_a: assert property (trip_s |=> s) else $error("trip");
    stop_latch_a: assert property (s && !k |=> s) else $error("latch");
    cancel_ignore_a: assert property (k && f |=> s) else $error("ignore");
    cancel_ok_a: assert property (s ##0 ok_s |=> !s) else $error("cancel");
    pin_safe_a: assert property (s |-> pwm_out_ch0_o && pwm_out_ch0_oe_o == !$past(hiz_mode_i))
        else $error("pin");
    ch1_run_a: assert property (s |-> pwm_out_ch1_oe_o) else $error("ch1");
endmodule // pwm_fos_assertions
bind pwm_forced_output_stop pwm_fos_assertions chk (.*);
`default_nettype wire

// File: testbench/overcurrent_model.sv
// Comparator model: sense against the threshold reference
`default_nettype none
module overcurrent_model (input wire logic [7:0] sense_i, output logic cmp_o);
    timeunit 1ns/1ps;
    localparam logic [7:0] DAC_REF = 8'h80;
    assign cmp_o = sense_i > DAC_REF;
endmodule // overcurrent_model
`default_nettype wire

// File: testbench/pwm_forced_output_stop_tb.sv
// Bench for the forced output stop block
`default_nettype none
module pwm_forced_output_stop_tb;
    timeunit 1ns/1ps;
    logic mclk_i = 0, resetn_i = 0, hiz = 0, k = 0;
    logic [15:0] d0 = 0, d1 = 0;
    logic [7:0] sense = 0;
    logic [33:0] rows [2] = '{{16'h0004, 16'h0000, 2'b10}, {16'h0000, 16'h0004, 2'b01}};
    wire c, p0, e0, p1, e1, f, s;
    wire [15:0] cnt;
    int bad_count = 0, num_checks = 0;
    always #2 mclk_i = ~mclk_i;
    overcurrent_model om (.sense_i(sense), .cmp_o(c));
    pwm_forced_output_stop dut (.mclk_i, .resetn_i, .timer_enable_i(1'b1),
        .period_i(16'h0003), .duty_ch0_i(d0), .duty_ch1_i(d1), .hiz_mode_i(hiz),
        .stop_cancel_trigger_i(k), .overcurrent_comparator_i(c), .pwm_out_ch0_o(p0),
        .pwm_out_ch0_oe_o(e0), .pwm_out_ch1_o(p1), .pwm_out_ch1_oe_o(e1),
        .overcurrent_flag_o(f), .forced_stop_o(s), .count_o(cnt));
    task chk(input logic [15:0] g, x);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %0t %h %h", $time, g, x);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task cancel;
        k = 1;
        tick(1);
        k = 0;
    endtask
    task final_report;
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task trip(input logic m);
        hiz = m;
        sense = 8'hC0;
        tick(3);
        chk({e1, p1, e0, p0, s}, {2'b11, ~m, 2'b11});
        cancel();
        tick(2);
        chk(s, 1'b1);
        sense = 8'h00;
        tick(4);
        chk({f, s}, 2'b01);
        cancel();
        tick(1);
        chk({e0, p0, s}, 3'b100);
        $display("trip %0d", m);
    endtask
    initial begin
        tick(2);
        chk({e0, e1, f, s}, 4'h0);
        resetn_i = 1;
        tick(1);
        chk(cnt, 16'h0001);
        $display("reset");
        foreach (rows[i]) begin
            {d0, d1} = rows[i][33:2];
            tick(6);
            chk({e1, e0, p0, p1}, {2'b11, rows[i][1:0]});
            $display("row %0d", i);
        end
        trip(0);
        trip(1);
        // Reset in mid-stop, comparator still high at release
        sense = 8'hC0;
        tick(3);
        resetn_i = 0;
        tick(1);
        chk({e0, e1, f, s}, 4'h0);
        chk(cnt, 16'h0000);
        resetn_i = 1;
        tick(3);
        chk({e0, p0, s}, 3'b011);
        sense = 8'h00;
        $display("midreset");
        final_report();
    end
    // Run needs about 50 cycles, so ten times that
    initial begin
        #2000;
        bad_count++;
        final_report();
    end
endmodule // pwm_forced_output_stop_tb
`default_nettype wire
